// ---- hdl/core_if.sv ----
// Connection between the core top, the register file and the operation unit
`timescale 1ns/100ps
`default_nettype none
interface core_if #(
  parameter int W = 32,
  parameter int SET_W = 2
);
  logic [2:0][SET_W-1:0] rd_set;
  logic [2:0][4:0] rd_idx;
  logic [2:0][W-1:0] rd_data;
  logic [1:0] wr_en;
  logic [1:0][SET_W-1:0] wr_set;
  logic [1:0][4:0] wr_idx;
  logic [1:0][W-1:0] wr_data;
  logic [3:0] alu_op;
  logic [W-1:0] alu_a;
  logic [W-1:0] alu_b;
  logic [W-1:0] alu_res;

  modport gpr_mp (input rd_set, rd_idx, wr_en, wr_set, wr_idx, wr_data, output rd_data);
  modport alu_mp (input alu_op, alu_a, alu_b, output alu_res);
  modport core_mp (output rd_set, rd_idx, wr_en, wr_set, wr_idx, wr_data, alu_op, alu_a, alu_b,
                   input rd_data, alu_res);
endinterface : core_if
`default_nettype wire

// ---- hdl/gpr_core_pkg.sv ----
// Shared constants, register map and types for the general register core
package gpr_core_pkg;

  // Datapath and file geometry
  localparam int GENERAL_REG_WIDTH = 32;
  localparam int SHADOW_SETS = 4;
  localparam int REG_IDX_W = 5;
  localparam int REG_COUNT = 32;
  localparam int FCC_W = 8;
  localparam int COC_W = 4;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SHADOW = 8'h04;
  localparam logic [7:0] OFS_ORDER = 8'h08;
  localparam logic [7:0] OFS_GPR_SEL = 8'h0C;
  localparam logic [7:0] OFS_GPR_DATA = 8'h10;
  localparam logic [7:0] OFS_FCC = 8'h14;

  // Field positions
  localparam int MODE_SWAP_POS = 0;
  localparam int CSS_LSB = 0;
  localparam int ORDER_MEM_POS = 0;
  localparam int ORDER_ACCESS_POS = 1;
  localparam int ORDER_SWAP_POS = 2;
  localparam int ORDER_LINK_POS = 3;
  localparam int ORDER_MODE_POS = 4;
  localparam int SEL_IDX_LSB = 0;
  localparam int SEL_SET_LSB = 8;
  localparam int COC_FCC_POS = 1;

  // Reset value, register zero index and compact map constants
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] COMPACT_HIGH_BASE = 5'h10;
  localparam logic [2:0] COMPACT_LOW_LIMIT = 3'h2;

  typedef enum logic [3:0] {
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_NOR,
    ALU_LT,
    ALU_GT,
    ALU_LE,
    ALU_GE,
    ALU_MOD
  } alu_op_t;

  // Compact register number to full index: 0,1 -> 16,17; 2..7 unchanged
  function automatic logic [4:0] xlat(input logic [2:0] c);
    if (c < COMPACT_LOW_LIMIT) begin
      xlat = COMPACT_HIGH_BASE | {2'b00, c};
    end else begin
      xlat = {2'b00, c};
    end
  endfunction : xlat

endpackage : gpr_core_pkg

// ---- hdl/gpr_file_endian_link_state.sv ----
// Architectural state core: shadow register sets, byte order, link flag, bus slave
//
// Notes on behaviour
// RL1: Every general register has one width, 32 or 64 bits, fixed by a parameter.
// RL2: Reading register zero always gives all zeros.
// RL3: Several complete register sets exist, addressed by set and register index.
// RL4: Instruction accesses use the set named by the current shadow set field.
// RL5: Memory byte order is caught at reset from a strap, 0 little and 1 big, and then held.
// RL6: Load/store byte order is the memory order XOR the swap flag.
// RL7: The swap flag is set only while the user swap bit is set and the core is in user mode.
// RL8: A completed linked load sets the link flag, and a conditional store tests it.
// RL9: The link flag clears when atomicity is lost and always on exception return; a linked load completing in the same cycle as the loss sets it instead.
// RL10: Floating condition flag zero always equals coprocessor one's condition signal.
// RL11: Compact register numbers are translated to full register indices before access.
// RL12: Less, greater, less-or-equal, greater-or-equal and modulo treat operands as signed.
// RL13: Bitwise NOR, XOR, AND and OR act on each bit independently.
// RL14: Writes to register zero of any set are dropped.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gpr_file_endian_link_state
  import gpr_core_pkg::*;
#(
  parameter int W = GENERAL_REG_WIDTH,
  parameter int NSETS = SHADOW_SETS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Straps and mode
  input wire logic memory_big_order_strap_i,
  input wire logic user_mode_i,
  // Operand read
  input wire logic rd_compact_i,
  input wire logic [4:0] rd_a_idx_i,
  input wire logic [4:0] rd_b_idx_i,
  output logic [W-1:0] op_a_o,
  output logic [W-1:0] op_b_o,
  // Operation unit
  input wire logic [3:0] alu_op_i,
  output logic [W-1:0] alu_result_o,
  // Result write
  input wire logic wr_en_i,
  input wire logic wr_compact_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [W-1:0] wr_data_i,
  // Atomic sequence
  input wire logic ll_done_i,
  input wire logic sc_i,
  input wire logic atomic_break_i,
  input wire logic eret_i,
  output logic link_reservation_flag_o,
  output logic sc_pass_o,
  // Byte order
  output logic memory_big_order_o,
  output logic swap_byte_order_flag_o,
  output logic access_big_order_o,
  // Condition flags
  input wire logic fcc_wr_en_i,
  input wire logic [FCC_W-1:0] fcc_wr_data_i,
  input wire logic [COC_W-1:0] coc_other_i,
  output logic [FCC_W-1:0] fp_condition_flag_o,
  output logic [COC_W-1:0] coprocessor_condition_signal_o,
  // Avalon-MM slave
  input wire logic [BUS_AW-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [BUS_DW-1:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [BUS_DW-1:0] readdata_o,
  output logic waitrequest_o
);
  localparam int SET_W = (NSETS > 1) ? $clog2(NSETS) : 1;

  typedef struct packed {
    logic mem_big;
    logic swap_bit;
    logic swap_flag;
    logic [SET_W-1:0] current_shadow_set;
    logic link;
    logic sc_pass;
    logic [FCC_W-1:0] fcc;
    logic ack;
    logic [BUS_DW-1:0] rdata;
    logic [SET_W-1:0] sel_set;
    logic [4:0] sel_idx;
    logic [W-1:0] op_a;
    logic [W-1:0] op_b;
    logic [W-1:0] alu_res;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;

  core_if #(.W(W), .SET_W(SET_W)) cif ();

  logic [4:0] rd_a_full;
  logic [4:0] rd_b_full;
  logic [4:0] wr_full;
  logic bus_req;
  logic bus_wr_now;
  logic [BUS_DW-1:0] gpr_word;
  logic [BUS_DW-1:0] rd_word;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      lane_merge[8*b +: 8] = be[b] ? new_w[8*b +: 8] : old_w[8*b +: 8];
    end
  endfunction : lane_merge

  shadow_reg_file #(.W(W), .NSETS(NSETS)) u_rf (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .rf(cif.gpr_mp)
  );

  int_op_unit #(.W(W)) u_alu (
    .alu(cif.alu_mp)
  );

  // Compact numbers go through the fixed map
  assign rd_a_full = rd_compact_i ? xlat(rd_a_idx_i[2:0]) : rd_a_idx_i; // RL11
  assign rd_b_full = rd_compact_i ? xlat(rd_b_idx_i[2:0]) : rd_b_idx_i; // RL11
  assign wr_full = wr_compact_i ? xlat(wr_idx_i[2:0]) : wr_idx_i; // RL11

  assign bus_req = read_i | write_i;
  assign bus_wr_now = write_i & st_reg.ack;

  // Instruction ports follow the current shadow set; bus port uses its own selection
  assign cif.rd_set[0] = st_reg.current_shadow_set; // RL4
  assign cif.rd_set[1] = st_reg.current_shadow_set; // RL4
  assign cif.rd_set[2] = st_reg.sel_set; // RL3
  assign cif.rd_idx[0] = rd_a_full;
  assign cif.rd_idx[1] = rd_b_full;
  assign cif.rd_idx[2] = st_reg.sel_idx;

  // Port 1 is the instruction write and wins a collision with the bus
  assign gpr_word = BUS_DW'(cif.rd_data[2]);
  assign cif.wr_en[0] = bus_wr_now && (address_i == OFS_GPR_DATA);
  assign cif.wr_set[0] = st_reg.sel_set; // RL3
  assign cif.wr_idx[0] = st_reg.sel_idx;
  assign cif.wr_data[0] = W'(lane_merge(gpr_word, writedata_i, byteenable_i));
  assign cif.wr_en[1] = wr_en_i;
  assign cif.wr_set[1] = st_reg.current_shadow_set; // RL4
  assign cif.wr_idx[1] = wr_full;
  assign cif.wr_data[1] = wr_data_i;

  assign cif.alu_op = alu_op_i;
  assign cif.alu_a = cif.rd_data[0];
  assign cif.alu_b = cif.rd_data[1];

  // Register read mux, unmapped addresses read zero
  always_comb begin
    rd_word = RST_WORD;
    case (address_i)
      OFS_MODE: rd_word[MODE_SWAP_POS] = st_reg.swap_bit;
      OFS_SHADOW: rd_word[CSS_LSB +: SET_W] = st_reg.current_shadow_set;
      OFS_ORDER: begin
        rd_word[ORDER_MEM_POS] = st_reg.mem_big;
        rd_word[ORDER_ACCESS_POS] = st_reg.mem_big ^ st_reg.swap_flag;
        rd_word[ORDER_SWAP_POS] = st_reg.swap_flag;
        rd_word[ORDER_LINK_POS] = st_reg.link;
        rd_word[ORDER_MODE_POS] = user_mode_i;
      end
      OFS_GPR_SEL: begin
        rd_word[SEL_IDX_LSB +: 5] = st_reg.sel_idx;
        rd_word[SEL_SET_LSB +: SET_W] = st_reg.sel_set;
      end
      OFS_GPR_DATA: rd_word = gpr_word;
      OFS_FCC: rd_word[FCC_W-1:0] = st_reg.fcc;
      default: rd_word = RST_WORD;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // One wait cycle, answer on the second cycle of each request
    st_next.ack = bus_req & ~st_reg.ack;
    if (read_i && !st_reg.ack) begin
      st_next.rdata = rd_word;
    end
    if (bus_wr_now) begin
      case (address_i)
        OFS_MODE: begin
          if (byteenable_i[0]) begin
            st_next.swap_bit = writedata_i[MODE_SWAP_POS];
          end
        end
        OFS_SHADOW: begin
          if (byteenable_i[0]) begin
            st_next.current_shadow_set = writedata_i[CSS_LSB +: SET_W]; // RL4
          end
        end
        OFS_GPR_SEL: begin
          if (byteenable_i[0]) begin
            st_next.sel_idx = writedata_i[SEL_IDX_LSB +: 5];
          end
          if (byteenable_i[1]) begin
            st_next.sel_set = writedata_i[SEL_SET_LSB +: SET_W];
          end
        end
        default: st_next.current_shadow_set = st_reg.current_shadow_set;
      endcase
    end
    // Swap only in user mode with the swap bit set
    st_next.swap_flag = st_reg.swap_bit & user_mode_i; // RL7
    // Exception return always clears; otherwise a new link beats a loss of atomicity
    if (eret_i) begin
      st_next.link = 1'b0; // RL9
    end else if (ll_done_i) begin
      st_next.link = 1'b1; // RL8
    end else if (atomic_break_i) begin
      st_next.link = 1'b0; // RL9
    end
    st_next.sc_pass = sc_i & st_reg.link; // RL8
    if (fcc_wr_en_i) begin
      st_next.fcc = fcc_wr_data_i;
    end
    st_next.op_a = cif.rd_data[0]; // RL2
    st_next.op_b = cif.rd_data[1];
    st_next.alu_res = cif.alu_res;
    if (reset_i) begin
      st_next = '0;
      // Byte order is sampled only while reset is held
      st_next.mem_big = memory_big_order_strap_i; // RL5
    end
  end

  always_ff @(posedge mclk_i) begin
    st_reg <= st_next;
  end

  assign op_a_o = st_reg.op_a;
  assign op_b_o = st_reg.op_b;
  assign alu_result_o = st_reg.alu_res;
  assign link_reservation_flag_o = st_reg.link;
  assign sc_pass_o = st_reg.sc_pass;
  assign memory_big_order_o = st_reg.mem_big; // RL5
  assign swap_byte_order_flag_o = st_reg.swap_flag;
  assign access_big_order_o = st_reg.mem_big ^ st_reg.swap_flag; // RL6
  assign fp_condition_flag_o = st_reg.fcc;

  // Flag zero and the coprocessor one signal come from the same flip-flop
  always_comb begin
    coprocessor_condition_signal_o = coc_other_i;
    coprocessor_condition_signal_o[COC_FCC_POS] = st_reg.fcc[0]; // RL10
  end

  assign readdata_o = st_reg.rdata;
  assign waitrequest_o = bus_req & ~st_reg.ack;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_zero_operand: assert property (rd_a_full == ZERO_REG |=> op_a_o == '0) // RL2
    else $error("register zero read back nonzero");
  a_compact_map: assert property (rd_compact_i && rd_a_idx_i[2:0] == 3'h1 |-> rd_a_full == 5'h11) // RL11
    else $error("compact number one not mapped to seventeen");
  a_mem_order_held: assert property (##1 $stable(memory_big_order_o)) // RL5
    else $error("memory byte order changed outside reset");
  a_swap_kernel_off: assert property (!user_mode_i |=> !swap_byte_order_flag_o) // RL7
    else $error("swap flag set outside user mode");
  a_swap_user_on: assert property (user_mode_i && st_reg.swap_bit && !bus_wr_now // RL6
    |=> access_big_order_o != memory_big_order_o)
    else $error("load store order not reversed in user mode");
  a_link_set: assert property (ll_done_i && !eret_i |=> link_reservation_flag_o) // RL8
    else $error("linked load did not set link flag");
  a_link_eret: assert property (eret_i |=> !link_reservation_flag_o) // RL9
    else $error("exception return did not clear link flag");
  a_link_break: assert property (atomic_break_i && !ll_done_i |=> !link_reservation_flag_o) // RL9
    else $error("loss of atomicity did not clear link flag");
  a_sc_tests_link: assert property (sc_i |=> sc_pass_o == $past(link_reservation_flag_o)) // RL8
    else $error("conditional store result does not follow link flag");
  a_fcc_mirror: assert property (fcc_wr_en_i |=> coprocessor_condition_signal_o[1] == $past(fcc_wr_data_i[0])) // RL10
    else $error("coprocessor condition differs from flag zero");
  a_signed_lt: assert property (alu_op_i == ALU_LT |=> alu_result_o == W'($signed($past(cif.rd_data[0])) // RL12
    < $signed($past(cif.rd_data[1]))))
    else $error("less than not signed");
  a_nor_bitwise: assert property (alu_op_i == ALU_NOR |=> alu_result_o == ~($past(cif.rd_data[0]) // RL13
    | $past(cif.rd_data[1])))
    else $error("nor result wrong");
  a_bus_answer: assert property ($rose(read_i) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("read not answered on second cycle");

  // Second operand port and compact map ends
  a_zero_operand_b: assert property (rd_b_full == ZERO_REG |=> op_b_o == '0) // RL2
    else $error("register zero read back nonzero on port b");
  a_compact_zero: assert property (rd_compact_i && rd_a_idx_i[2:0] == 3'h0 |-> rd_a_full == 5'h10) // RL11
    else $error("compact number zero not mapped to sixteen");
  a_compact_high: assert property (rd_compact_i && rd_b_idx_i[2:0] > 3'h1 // RL11
    |-> rd_b_full == 5'(rd_b_idx_i[2:0]))
    else $error("compact number above one was remapped");

  // Swap flag and link flag side conditions
  a_swap_needs_bit: assert property (!st_reg.swap_bit |=> !swap_byte_order_flag_o) // RL7
    else $error("swap flag set without the user swap bit");
  a_sc_no_link: assert property (!link_reservation_flag_o |=> !sc_pass_o) // RL8
    else $error("conditional store passed without a link");
  a_link_hold: assert property (!ll_done_i && !atomic_break_i && !eret_i // RL9
    |=> link_reservation_flag_o == $past(link_reservation_flag_o))
    else $error("link flag changed with no event");

  // Operation unit, operands as read one cycle earlier
  a_signed_gt: assert property (alu_op_i == ALU_GT |=> alu_result_o == // RL12
    W'($signed($past(cif.rd_data[0])) > $signed($past(cif.rd_data[1]))))
    else $error("greater than not signed");
  a_signed_le: assert property (alu_op_i == ALU_LE |=> alu_result_o == // RL12
    W'($signed($past(cif.rd_data[0])) <= $signed($past(cif.rd_data[1]))))
    else $error("less or equal not signed");
  a_signed_ge: assert property (alu_op_i == ALU_GE |=> alu_result_o == // RL12
    W'($signed($past(cif.rd_data[0])) >= $signed($past(cif.rd_data[1]))))
    else $error("greater or equal not signed");
  a_mod_signed: assert property (alu_op_i == ALU_MOD && cif.rd_data[1] != '0 |=> alu_result_o == // RL12
    W'($signed($past(cif.rd_data[0])) % $signed($past(cif.rd_data[1]))))
    else $error("modulo not signed");
  a_mod_zero: assert property (alu_op_i == ALU_MOD && cif.rd_data[1] == '0 |=> alu_result_o == '0) // RL12
    else $error("modulo by zero not zero");
  a_and_bitwise: assert property (alu_op_i == ALU_AND |=> alu_result_o == // RL13
    ($past(cif.rd_data[0]) & $past(cif.rd_data[1])))
    else $error("and result wrong");
  a_or_bitwise: assert property (alu_op_i == ALU_OR |=> alu_result_o == // RL13
    ($past(cif.rd_data[0]) | $past(cif.rd_data[1])))
    else $error("or result wrong");
  a_xor_bitwise: assert property (alu_op_i == ALU_XOR |=> alu_result_o == // RL13
    ($past(cif.rd_data[0]) ^ $past(cif.rd_data[1])))
    else $error("xor result wrong");

  // Writes answer after the same single wait cycle as reads
  a_bus_write_answer: assert property ($rose(write_i) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("write not answered on second cycle");
  a_css_write: assert property (bus_wr_now && address_i == OFS_SHADOW && byteenable_i[0] // RL4
    |=> st_reg.current_shadow_set == $past(writedata_i[CSS_LSB +: SET_W]))
    else $error("current set not taken from the bus write");

  c_link_pass: cover property (ll_done_i ##1 sc_i ##1 sc_pass_o);
  c_swap_active: cover property (user_mode_i && st_reg.swap_bit ##1 swap_byte_order_flag_o);
  c_bus_gpr_write: cover property (bus_wr_now && address_i == OFS_GPR_DATA);
  // Main scenarios reached
  c_link_eret: cover property (link_reservation_flag_o && eret_i ##1 !link_reservation_flag_o);
  c_set_switch: cover property (bus_wr_now && address_i == OFS_SHADOW);
endmodule : gpr_file_endian_link_state
`default_nettype wire

// ---- hdl/int_op_unit.sv ----
// Bitwise and signed comparison / modulo unit
`timescale 1ns/100ps
`default_nettype none
module int_op_unit
  import gpr_core_pkg::*;
#(
  parameter int W = GENERAL_REG_WIDTH
) (
  core_if.alu_mp alu
);
  logic signed [W-1:0] sa;
  logic signed [W-1:0] sb;

  assign sa = alu.alu_a;
  assign sb = alu.alu_b;

  always_comb begin
    case (alu_op_t'(alu.alu_op))
      ALU_AND: alu.alu_res = alu.alu_a & alu.alu_b; // RL13
      ALU_OR: alu.alu_res = alu.alu_a | alu.alu_b; // RL13
      ALU_XOR: alu.alu_res = alu.alu_a ^ alu.alu_b; // RL13
      ALU_NOR: alu.alu_res = ~(alu.alu_a | alu.alu_b); // RL13
      ALU_LT: alu.alu_res = W'(sa < sb); // RL12
      ALU_GT: alu.alu_res = W'(sa > sb); // RL12
      ALU_LE: alu.alu_res = W'(sa <= sb); // RL12
      ALU_GE: alu.alu_res = W'(sa >= sb); // RL12
      // Zero divisor gives zero rather than an undefined value
      ALU_MOD: alu.alu_res = (sb == '0) ? '0 : W'(sa % sb); // RL12
      default: alu.alu_res = '0;
    endcase
  end
endmodule : int_op_unit
`default_nettype wire

// ---- hdl/shadow_reg_file.sv ----
// Banked general register file with shadow sets, three read and two write ports
`timescale 1ns/100ps
`default_nettype none
module shadow_reg_file
  import gpr_core_pkg::*;
#(
  parameter int W = GENERAL_REG_WIDTH,
  parameter int NSETS = SHADOW_SETS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Core side
  core_if.gpr_mp rf
);
  typedef struct packed {
    logic [NSETS-1:0][REG_COUNT-1:0][W-1:0] r;
  } rf_state_t;

  rf_state_t rf_reg;
  rf_state_t rf_next;

  // Later port wins on a same-address collision
  always_comb begin
    rf_next = rf_reg;
    for (int p = 0; p < 2; p++) begin
      if (rf.wr_en[p] && rf.wr_idx[p] != ZERO_REG) begin // RL14
        rf_next.r[rf.wr_set[p]][rf.wr_idx[p]] = rf.wr_data[p]; // RL3
      end
    end
    if (reset_i) begin
      rf_next = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    rf_reg <= rf_next;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rd
      assign rf.rd_data[g] = (rf.rd_idx[g] == ZERO_REG) ? '0 : rf_reg.r[rf.rd_set[g]][rf.rd_idx[g]]; // RL1 RL2
    end
    for (g = 0; g < NSETS; g++) begin : g_zero
      a_zero_stays_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
        rf_reg.r[g][0] == '0) else $error("register zero of a set became nonzero"); // RL14
    end
  endgenerate
endmodule : shadow_reg_file
`default_nettype wire

// ---- tb/gpr_file_endian_link_state_bench.sv ----
// Directed bench for the register core: operand ports, Avalon-MM registers, byte order and link flag
`timescale 1ns/100ps
`default_nettype none
module gpr_file_endian_link_state_bench;
  import gpr_core_pkg::*;
  logic mclk_i, reset_i, strap, umode, rcomp, wen, wcomp, ll, sc, brk, eret, fwen, rd, wr, wq, sp, lf, mb, sw, ab;
  logic [4:0] ia, ib, widx;
  logic [3:0] op, be, coco, coprocessor_condition_signal;
  logic [31:0] wdat, opa, opb, res, wd, rdat, got;
  logic [7:0] fdat, fcc, addr;
  int error_cnt, checks_done, cycles;

  gpr_file_endian_link_state uut (.mclk_i(mclk_i), .reset_i(reset_i), .memory_big_order_strap_i(strap),
    .user_mode_i(umode), .rd_compact_i(rcomp), .rd_a_idx_i(ia), .rd_b_idx_i(ib), .op_a_o(opa), .op_b_o(opb),
    .alu_op_i(op), .alu_result_o(res), .wr_en_i(wen), .wr_compact_i(wcomp), .wr_idx_i(widx), .wr_data_i(wdat),
    .ll_done_i(ll), .sc_i(sc), .atomic_break_i(brk), .eret_i(eret), .link_reservation_flag_o(lf),
    .sc_pass_o(sp), .memory_big_order_o(mb), .swap_byte_order_flag_o(sw), .access_big_order_o(ab),
    .fcc_wr_en_i(fwen), .fcc_wr_data_i(fdat), .coc_other_i(coco), .fp_condition_flag_o(fcc),
    .coprocessor_condition_signal_o(coprocessor_condition_signal), .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wd),
    .byteenable_i(be), .readdata_o(rdat), .waitrequest_o(wq));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Hang guard: whole directed run is under 150 cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    checks_done = checks_done + 1;
    if (act !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %h seen %h", name, exp, act);
    end
  endtask : chk

  // Avalon-MM access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] lanes);
    @(posedge mclk_i);
    rd <= ~is_wr;
    wr <= is_wr;
    addr <= a;
    wd <= d;
    be <= lanes;
    do begin
      @(posedge mclk_i);
    end while (wq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic gwrite(input logic c, input logic [4:0] i, input logic [31:0] d);
    @(posedge mclk_i);
    wen <= 1'b1;
    wcomp <= c;
    widx <= i;
    wdat <= d;
    @(posedge mclk_i);
    wen <= 1'b0;
  endtask : gwrite

  task automatic gread(input logic c, input logic [4:0] a, input logic [4:0] b, input logic [3:0] o);
    @(posedge mclk_i);
    rcomp <= c;
    ia <= a;
    ib <= b;
    op <= o;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : gread

  // Event pulses {ll_done, sc, atomic_break, eret}
  task automatic pulse(input logic [3:0] p);
    @(posedge mclk_i);
    {ll, sc, brk, eret} <= p;
    @(posedge mclk_i);
    {ll, sc, brk, eret} <= 4'h0;
    @(negedge mclk_i);
  endtask : pulse

  logic [31:0] exp_ab [2][9] = '{
    '{32'h0000_0004, 32'hFFFF_FFFF, 32'hFFFF_FFFB, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
      32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFD},
    '{32'h0000_0004, 32'hFFFF_FFFF, 32'hFFFF_FFFB, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001,
      32'h0000_0000, 32'h0000_0001, 32'h0000_0000}};

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    reset_i = 1'b1;
    strap = 1'b1;
    {umode, rcomp, wen, wcomp, ll, sc, brk, eret, fwen, rd, wr} = '0;
    {ia, ib, widx, op, wdat, fdat, addr, wd} = '0;
    coco = 4'hA;
    be = 4'hF;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    strap <= 1'b0;
    @(negedge mclk_i);
    chk("mem_order", 32'h0000_0001, {31'h0, mb});
    bus(1'b0, OFS_ORDER, 32'h0000_0000, 4'hF);
    chk("order_reg", 32'h0000_0003, got);
    // Register zero keeps reading zero through both write paths
    gwrite(1'b0, 5'd0, 32'h1234_5678);
    bus(1'b1, OFS_GPR_SEL, 32'h0000_0000, 4'hF);
    bus(1'b1, OFS_GPR_DATA, 32'h5555_AAAA, 4'hF);
    gread(1'b0, 5'd0, 5'd0, 4'h0);
    chk("r0", 32'h0000_0000, opa);
    chk("r0_b", 32'h0000_0000, opb);
    // Signed compare, modulo and bitwise ops, both operand orders
    gwrite(1'b0, 5'd5, 32'hFFFF_FFFD);
    gwrite(1'b0, 5'd6, 32'h0000_0006);
    for (int k = 0; k < 9; k++) begin
      gread(1'b0, 5'd5, 5'd6, 4'(k));
      chk("alu_ab", exp_ab[0][k], res);
      gread(1'b0, 5'd6, 5'd5, 4'(k));
      chk("alu_ba", exp_ab[1][k], res);
    end
    chk("op_b", 32'hFFFF_FFFD, opb);
    gread(1'b0, 5'd5, 5'd0, 4'h8);
    chk("mod_zero", 32'h0000_0000, res);
    // Compact numbers 0 and 1 reach registers 16 and 17
    gwrite(1'b1, 5'd0, 32'h0000_0016);
    gwrite(1'b1, 5'd1, 32'h0000_0017);
    gread(1'b0, 5'd16, 5'd17, 4'h0);
    chk("xlat_w0", 32'h0000_0016, opa);
    chk("xlat_w1", 32'h0000_0017, opb);
    gread(1'b1, 5'd1, 5'd5, 4'h0);
    chk("xlat_r1", 32'h0000_0017, opa);
    chk("xlat_r5", 32'hFFFF_FFFD, opb);
    // Shadow sets are independent copies
    bus(1'b1, OFS_SHADOW, 32'h0000_0002, 4'hF);
    gread(1'b0, 5'd5, 5'd6, 4'h0);
    chk("set2_empty", 32'h0000_0000, opa);
    gwrite(1'b0, 5'd5, 32'h0000_0222);
    gread(1'b0, 5'd5, 5'd6, 4'h0);
    chk("set2_r5", 32'h0000_0222, opa);
    bus(1'b1, OFS_GPR_SEL, 32'h0000_0105, 4'hF);
    bus(1'b1, OFS_GPR_DATA, 32'hCAFE_0001, 4'hF);
    bus(1'b1, OFS_GPR_DATA, 32'h0000_00EE, 4'h1);
    bus(1'b0, OFS_GPR_DATA, 32'h0000_0000, 4'hF);
    chk("set1_merge", 32'hCAFE_00EE, got);
    bus(1'b1, OFS_SHADOW, 32'h0000_0001, 4'hF);
    gread(1'b0, 5'd5, 5'd6, 4'h0);
    chk("set1_r5", 32'hCAFE_00EE, opa);
    bus(1'b1, OFS_SHADOW, 32'h0000_0000, 4'hF);
    gread(1'b0, 5'd5, 5'd6, 4'h0);
    chk("set0_r5", 32'hFFFF_FFFD, opa);
    // Byte order swap only in user mode with swap bit set
    bus(1'b1, OFS_MODE, 32'h0000_0001, 4'hF);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("swap_kernel", 32'h0000_0001, {30'h0, sw, ab});
    @(posedge mclk_i);
    umode <= 1'b1;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("swap_user", 32'h0000_0002, {30'h0, sw, ab});
    bus(1'b1, OFS_ORDER, 32'h0000_0000, 4'hF);
    bus(1'b0, OFS_ORDER, 32'h0000_0000, 4'hF);
    chk("order_ro", 32'h0000_0015, got);
    bus(1'b1, OFS_MODE, 32'h0000_0000, 4'hF);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("swap_off", 32'h0000_0001, {30'h0, sw, ab});
    chk("mem_hold", 32'h0000_0001, {31'h0, mb});
    @(posedge mclk_i);
    umode <= 1'b0;
    // Link flag: set, test, break, return
    pulse(4'b0100);
    chk("sc_nolink", 32'h0000_0000, {30'h0, lf, sp});
    pulse(4'b1000);
    chk("ll_set", 32'h0000_0002, {30'h0, lf, sp});
    pulse(4'b0100);
    chk("sc_pass", 32'h0000_0003, {30'h0, lf, sp});
    pulse(4'b1010);
    chk("ll_vs_break", 32'h0000_0002, {30'h0, lf, sp});
    pulse(4'b0010);
    chk("break", 32'h0000_0000, {30'h0, lf, sp});
    pulse(4'b1000);
    pulse(4'b1001);
    chk("eret", 32'h0000_0000, {30'h0, lf, sp});
    // Condition flag zero mirrors coprocessor one condition
    chk("coc_clear", 32'h0000_0008, {28'h0, coprocessor_condition_signal});
    @(posedge mclk_i);
    fwen <= 1'b1;
    fdat <= 8'h81;
    coco <= 4'h5;
    @(posedge mclk_i);
    fwen <= 1'b0;
    @(negedge mclk_i);
    chk("fcc", 32'h0000_0081, {24'h0, fcc});
    chk("coc_set", 32'h0000_0007, {28'h0, coprocessor_condition_signal});
    bus(1'b0, OFS_FCC, 32'h0000_0000, 4'hF);
    chk("fcc_reg", 32'h0000_0081, got);
    bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
    chk("unmapped", 32'h0000_0000, got);
    end_of_test();
  end
endmodule : gpr_file_endian_link_state_bench
`default_nettype wire
